// *** logic/scan_pkg.sv ***
// Shared constants, codes and types for the scan register set
package scan_pkg;

    // Chain lengths
    localparam int IR_LEN  = 8;              // Instruction shift chain
    localparam int BYP_LEN = 1;              // Bypass chain
    localparam int ID_LEN  = 32;             // Identification / mode capture chain
    localparam int BSR_LEN = 135;            // Boundary-scan cells

    // Instruction codes
    localparam logic [7:0] INS_EXTEST   = 8'h00;
    localparam logic [7:0] INS_IDCODE   = 8'h21;
    localparam logic [7:0] INS_SAMPLE   = 8'h05;
    localparam logic [7:0] INS_CLAMP    = 8'h07;
    localparam logic [7:0] INS_HIGHZ    = 8'h03;
    localparam logic [7:0] INS_DUAL_MR  = 8'h25;   // dual_mode_readback_instr
    localparam logic [7:0] INS_THIRD_MR = 8'h29;
    localparam logic [7:0] INS_BYPASS   = 8'hFF;
    localparam logic [7:0] IR_CAPTURE   = 8'h01;   // Fixed pattern loaded at capture-IR

    // Identification word layout
    localparam int ID_REV_LSB = 28;          // Revision 31:28
    localparam int ID_DEV_LSB = 12;          // Device code 27:12
    localparam int ID_VEN_LSB = 1;           // Vendor code 11:1
    // Dual mode word layout
    localparam int DM_SECOND_LSB = 17;       // Second mode word 28:17
    localparam int DM_REPAIR_BIT = 13;       // Repair capable flag
    localparam int DM_FIRST_LSB  = 1;        // First mode word 12:1
    // Third mode word layout
    localparam int TM_THIRD_LSB = 1;         // Third mode word 10:1

    // Register byte offsets
    localparam logic [11:0] OFF_MODE01 = 12'h000;  // First and second mode words
    localparam logic [11:0] OFF_MODE2  = 12'h004;  // Third mode word
    localparam logic [11:0] OFF_IDCFG  = 12'h008;  // Revision, device code, repair flag
    localparam logic [11:0] OFF_STATUS = 12'h00C;  // Read-only scan state

    // Register field positions
    localparam int MODE01_SECOND_LSB = 12;
    localparam int IDCFG_DEV_LSB     = 4;
    localparam int IDCFG_REPAIR_BIT  = 20;
    localparam int STAT_STATE_LSB    = 8;
    localparam int STAT_HIGHZ_BIT    = 24;
    localparam int STAT_DRIVE_BIT    = 25;

    // Register reset values
    localparam logic [23:0] MODE01_RST = 24'h000000;
    localparam logic [9:0]  MODE2_RST  = 10'h000;
    localparam logic [3:0]  REV_RST    = 4'h0;
    localparam logic [15:0] DEV_RST    = 16'h5A3C;     // Arbitrary neutral device code
    localparam logic [10:0] VENDOR_ID  = 11'h3A1;      // Arbitrary neutral vendor code

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Test state machine, one-hot
    typedef enum logic [15:0] {
        ST_RESET   = 16'h0001,
        ST_IDLE    = 16'h0002,
        ST_SEL_DR  = 16'h0004,
        ST_CAP_DR  = 16'h0008,
        ST_SH_DR   = 16'h0010,
        ST_EX1_DR  = 16'h0020,
        ST_PAU_DR  = 16'h0040,
        ST_EX2_DR  = 16'h0080,
        ST_UPD_DR  = 16'h0100,
        ST_SEL_IR  = 16'h0200,
        ST_CAP_IR  = 16'h0400,
        ST_SH_IR   = 16'h0800,
        ST_EX1_IR  = 16'h1000,
        ST_PAU_IR  = 16'h2000,
        ST_EX2_IR  = 16'h4000,
        ST_UPD_IR  = 16'h8000
    } tap_state_t;

    // Data chain selected by an instruction
    typedef enum logic [2:0] {
        SEL_BYPASS = 3'h1,
        SEL_ID     = 3'h2,
        SEL_BSR    = 3'h4
    } chain_sel_t;

endpackage : scan_pkg

// *** logic/scan_register_set.sv ***
// Scan instruction and data chains with an AXI4-Lite side port
//
// Contract
// - Chains of 8, 1, 32 and 135 bits
// - Extest and sample capture ring, route boundary
// - Identification code loads word, routes 32-bit chain
// - Clamp: bypass routed, pins from boundary cells
// - High-Z: bypass routed, all outputs floated
// - Dual readback loads first and second words
// - Third readback loads third mode word
// - Bypass code routes single bypass bit
// - Sample, identification, readback and bypass codes leave normal operation undisturbed
// - Identification bits 31:28 hold revision
// - Identification bits 27:12 hold device code
// - Identification bits 11:1 hold vendor code
// - Identification bit 0 always one
// - Dual word bits 31:29, 16:14 zero
// - Dual word bits 28:17 second mode word
// - Dual word bit 13 repair flag
// - Dual bits 12:1 first word, bit0 one
// - Third word bits 10:1 hold register
// - Third word bit 0 always one
// - Boundary cells ordered one to 135
// - Identification active after reset and test-reset
// - New instruction acts only at update-IR
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps

module scan_register_set
    import scan_pkg::*;
#(
    parameter int BSR_W = BSR_LEN           // Boundary chain length
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // Test port pins
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    output logic                    tdo,
    output logic                    tdo_oe,
    // Ball ring
    input  wire logic [BSR_W-1:0]   ring_in,
    input  wire logic [BSR_W-1:0]   core_out,
    input  wire logic [BSR_W-1:0]   core_oe,
    output logic                    [BSR_W-1:0] pin_out,
    output logic                    [BSR_W-1:0] pin_oe,
    // AXI4-Lite write channels
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);

    // Map an instruction to its data chain; unknown codes fall to bypass
    function automatic chain_sel_t chain_of(input logic [7:0] ins);
        if (ins == INS_EXTEST || ins == INS_SAMPLE) begin
            return SEL_BSR;
        end else if (ins == INS_IDCODE || ins == INS_DUAL_MR || ins == INS_THIRD_MR) begin
            return SEL_ID;
        end else begin
            return SEL_BYPASS;
        end
    endfunction : chain_of

    // Merge a write into a register word under byte enables
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    // Software-visible state
    logic [23:0]        mode01_q;             // Second word high, first word low
    logic [9:0]         mode2_q;              // Third mode word
    logic [3:0]         rev_q;                // Revision field
    logic [15:0]        dev_q;                // Device code field
    logic               repair_capable_flag_q;
    logic [31:0]        mode01_m;             // Mode word after byte enables
    logic [31:0]        mode2_m;              // Third word after byte enables
    logic [31:0]        idcfg_m;              // Identity fields after byte enables

    // Pin synchronisers
    logic [2:0]         tck_s_q;
    logic [2:0]         tms_s_q;
    logic [2:0]         tdi_s_q;
    logic               tck_lvl_q;            // Settled test clock level
    logic               tms_lvl_q;
    logic               tdi_lvl_q;
    logic [BSR_W-1:0]   ring_s1_q;
    logic [BSR_W-1:0]   ring_s2_q;
    logic [BSR_W-1:0]   ring_s3_q;
    logic [BSR_W-1:0]   ring_lvl_q;           // Settled ring snapshot source
    logic               tck_rise;
    logic               tck_fall;

    // Scan state
    tap_state_t         state_q;
    tap_state_t         state_d;
    logic [IR_LEN-1:0]  ir_sh_q;              // Instruction shift stage
    logic [IR_LEN-1:0]  ir_act_q;             // Active instruction
    logic               byp_q;                // Bypass bit
    logic [ID_LEN-1:0]  id_sh_q;              // Identification / mode chain
    logic [BSR_W-1:0]   bsr_sh_q;             // Boundary shift stage
    logic [BSR_W-1:0]   bsr_upd_q;            // Boundary update stage
    chain_sel_t         sel;
    logic               ring_drive;           // Pins follow boundary cells
    logic               ring_float;           // Pins forced off

    // AXI bookkeeping
    logic               aw_held_q;
    logic [11:0]        aw_addr_q;
    logic               w_held_q;
    logic [31:0]        w_data_q;
    logic [3:0]         w_strb_q;

    assign sel        = chain_of(ir_act_q);
    assign ring_drive = (ir_act_q == INS_EXTEST) || (ir_act_q == INS_CLAMP);
    assign ring_float = (ir_act_q == INS_HIGHZ);
    assign tck_rise   = !tck_lvl_q && tck_s_q[1] && tck_s_q[2];
    assign tck_fall   = tck_lvl_q && !tck_s_q[1] && !tck_s_q[2];
    // Merged write words; only the held low bits of each are kept
    assign mode01_m   = merge_strb({8'h00, mode01_q}, w_data_q, w_strb_q);
    assign mode2_m    = merge_strb({22'h000000, mode2_q}, w_data_q, w_strb_q);
    assign idcfg_m    = merge_strb({11'h000, repair_capable_flag_q, dev_q, rev_q},
                                   w_data_q, w_strb_q);

    // Three-stage synchronisers; a level counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tck_s_q   <= 3'h0;
            tms_s_q   <= 3'h7;
            tdi_s_q   <= 3'h7;
            tck_lvl_q <= 1'b0;
            tms_lvl_q <= 1'b1;
            tdi_lvl_q <= 1'b1;
        end else begin
            tck_s_q <= {tck_s_q[1:0], tck};
            tms_s_q <= {tms_s_q[1:0], tms};
            tdi_s_q <= {tdi_s_q[1:0], tdi};
            if (tck_s_q[1] == tck_s_q[2]) begin
                tck_lvl_q <= tck_s_q[2];
            end
            if (tms_s_q[1] == tms_s_q[2]) begin
                tms_lvl_q <= tms_s_q[2];
            end
            if (tdi_s_q[1] == tdi_s_q[2]) begin
                tdi_lvl_q <= tdi_s_q[2];
            end
        end
    end

    // Ring synchroniser; a ball in transition keeps its last settled level until stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ring_s1_q  <= '0;
            ring_s2_q  <= '0;
            ring_s3_q  <= '0;
            ring_lvl_q <= '0;
        end else begin
            ring_s1_q  <= ring_in;
            ring_s2_q  <= ring_s1_q;
            ring_s3_q  <= ring_s2_q;
            ring_lvl_q <= (~(ring_s2_q ^ ring_s3_q) & ring_s3_q)
                        | ((ring_s2_q ^ ring_s3_q) & ring_lvl_q);
        end
    end

    // Next test state from the settled mode select
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET:  state_d = tms_lvl_q ? ST_RESET  : ST_IDLE;
            ST_IDLE:   state_d = tms_lvl_q ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tms_lvl_q ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms_lvl_q ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  state_d = tms_lvl_q ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_d = tms_lvl_q ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_d = tms_lvl_q ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_d = tms_lvl_q ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_d = tms_lvl_q ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tms_lvl_q ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: state_d = tms_lvl_q ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  state_d = tms_lvl_q ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_d = tms_lvl_q ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_d = tms_lvl_q ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_d = tms_lvl_q ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_d = tms_lvl_q ? ST_SEL_DR : ST_IDLE;
            default:   state_d = ST_RESET;
        endcase
    end

    // Test state advances on each settled test clock rise
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // Instruction chain; the active code changes only at update-IR or test-logic-reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ir_sh_q  <= INS_IDCODE;
            ir_act_q <= INS_IDCODE;
        end else if (tck_rise) begin
            if (state_q == ST_RESET) begin
                ir_act_q <= INS_IDCODE;
            end else if (state_q == ST_CAP_IR) begin
                ir_sh_q <= IR_CAPTURE;
            end else if (state_q == ST_SH_IR) begin
                ir_sh_q <= {tdi_lvl_q, ir_sh_q[IR_LEN-1:1]};
            end else if (state_q == ST_UPD_IR) begin
                ir_act_q <= ir_sh_q;
            end
        end
    end

    // Bypass bit captures zero and shifts one place
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            byp_q <= 1'b0;
        end else if (tck_rise && sel == SEL_BYPASS) begin
            if (state_q == ST_CAP_DR) begin
                byp_q <= 1'b0;
            end else if (state_q == ST_SH_DR) begin
                byp_q <= tdi_lvl_q;
            end
        end
    end

    // Identification chain: capture word depends on the active code
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            id_sh_q <= '0;
        end else if (tck_rise && sel == SEL_ID) begin
            if (state_q == ST_CAP_DR) begin
                if (ir_act_q == INS_DUAL_MR) begin
                    id_sh_q <= '0;
                    id_sh_q[DM_SECOND_LSB +: 12] <= mode01_q[MODE01_SECOND_LSB +: 12];
                    id_sh_q[DM_REPAIR_BIT] <= repair_capable_flag_q;
                    id_sh_q[DM_FIRST_LSB +: 12] <= mode01_q[11:0];
                    id_sh_q[0] <= 1'b1;
                end else if (ir_act_q == INS_THIRD_MR) begin
                    // Undefined upper bits are captured as zero
                    id_sh_q <= '0;
                    id_sh_q[TM_THIRD_LSB +: 10] <= mode2_q;
                    id_sh_q[0] <= 1'b1;
                end else begin
                    id_sh_q[ID_REV_LSB +: 4]  <= rev_q;
                    id_sh_q[ID_DEV_LSB +: 16] <= dev_q;
                    id_sh_q[ID_VEN_LSB +: 11] <= VENDOR_ID;
                    id_sh_q[0] <= 1'b1;
                end
            end else if (state_q == ST_SH_DR) begin
                id_sh_q <= {tdi_lvl_q, id_sh_q[ID_LEN-1:1]};
            end
        end
    end

    // Boundary chain: cell one sits next to the serial output
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bsr_sh_q <= '0;
        end else if (tck_rise && sel == SEL_BSR) begin
            if (state_q == ST_CAP_DR) begin
                bsr_sh_q <= ring_lvl_q;
            end else if (state_q == ST_SH_DR) begin
                bsr_sh_q <= {tdi_lvl_q, bsr_sh_q[BSR_W-1:1]};
            end
        end
    end

    // Boundary update stage holds preloaded drive values
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bsr_upd_q <= '0;
        end else if (tck_rise && sel == SEL_BSR && state_q == ST_UPD_DR) begin
            bsr_upd_q <= bsr_sh_q;
        end
    end

    // Serial output changes on the falling test clock, enabled only while shifting
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (state_q == ST_SH_DR) || (state_q == ST_SH_IR);
            if (state_q == ST_SH_IR) begin
                tdo <= ir_sh_q[0];
            end else if (sel == SEL_BSR) begin
                tdo <= bsr_sh_q[0];
            end else if (sel == SEL_ID) begin
                tdo <= id_sh_q[0];
            end else begin
                tdo <= byp_q;
            end
        end
    end

    // Ball drivers: mission path unless clamp, extest or high-z takes over
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else if (ring_float) begin
            pin_out <= core_out;
            pin_oe  <= '0;
        end else if (ring_drive) begin
            pin_out <= bsr_upd_q;
            pin_oe  <= '1;
        end else begin
            pin_out <= core_out;
            pin_oe  <= core_oe;
        end
    end

    // Write address and data are taken independently, one write at a time
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 12'h000;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (aw_held_q && w_held_q && !s_axi_bvalid) begin
                aw_held_q <= 1'b0;
            end else if (!aw_held_q && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (aw_held_q && w_held_q && !s_axi_bvalid) begin
                w_held_q <= 1'b0;
            end else if (!w_held_q && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register writes and the write response
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= RESP_OKAY;
            mode01_q              <= MODE01_RST;
            mode2_q               <= MODE2_RST;
            rev_q                 <= REV_RST;
            dev_q                 <= DEV_RST;
            repair_capable_flag_q <= 1'b0;
        end else if (aw_held_q && w_held_q && !s_axi_bvalid) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_OKAY;
            if (aw_addr_q == OFF_MODE01) begin
                mode01_q <= mode01_m[23:0];
            end else if (aw_addr_q == OFF_MODE2) begin
                mode2_q <= mode2_m[9:0];
            end else if (aw_addr_q == OFF_IDCFG) begin
                {repair_capable_flag_q, dev_q, rev_q} <= idcfg_m[20:0];
            end else if (aw_addr_q == OFF_STATUS) begin
                s_axi_bresp <= RESP_OKAY;                         // Read-only, write ignored
            end else begin
                s_axi_bresp <= RESP_SLVERR;                       // Unmapped
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Reads answer one cycle after the address is taken
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
            if (s_axi_araddr == OFF_MODE01) begin
                s_axi_rdata[23:0] <= mode01_q;
            end else if (s_axi_araddr == OFF_MODE2) begin
                s_axi_rdata[9:0] <= mode2_q;
            end else if (s_axi_araddr == OFF_IDCFG) begin
                s_axi_rdata[20:0] <= {repair_capable_flag_q, dev_q, rev_q};
            end else if (s_axi_araddr == OFF_STATUS) begin
                s_axi_rdata[IR_LEN-1:0]          <= ir_act_q;
                s_axi_rdata[STAT_STATE_LSB +: 16] <= state_q;
                s_axi_rdata[STAT_HIGHZ_BIT]       <= ring_float;
                s_axi_rdata[STAT_DRIVE_BIT]       <= ring_drive;
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : scan_register_set

// *** sim/jtag_scan_register_set_tb.sv ***
// Self-checking bench for the scan register set
`timescale 1ns/1ps
module jtag_scan_register_set_tb import scan_pkg::*; ;
    logic sys_clk = 0, rst_n = 0, tck, tms, tdi, tdo, tdo_oe;
    logic [134:0] ring_in = {45{3'h6}}, core_out = {45{3'h5}}, core_oe = {45{3'h3}};
    logic [134:0] pin_out, pin_oe;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [135:0] q;
    int error_cnt = 0, comparisons = 0;
    scan_register_set dut_u (.*);
    tap_ctrl_model ctl_u (.sys_clk, .tdo, .tck, .tms, .tdi);
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [135:0] g, e);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic a_r, w_r, b_v;
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge sys_clk);
            {a_r, w_r, b_v, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge sys_clk);
            if (a_r) s_axi_awvalid <= 1'b0;
            if (w_r) s_axi_wvalid <= 1'b0;
        end while (b_v !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        logic a_r, r_v;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge sys_clk);
            {a_r, r_v, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge sys_clk);
            if (a_r) s_axi_arvalid <= 1'b0;
        end while (r_v !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic ir(input logic [7:0] c);
        ctl_u.scan(1'b1, {128'h0, c}, 8, q);
        chk(q[7:0], IR_CAPTURE);
    endtask : ir
    task automatic t_id();
        ctl_u.tlr();
        ctl_u.scan(1'b0, 136'h0, 32, q);
        chk(q[31:0], {REV_RST, DEV_RST, VENDOR_ID, 1'b1});
        chk(tdo_oe, 1'b0);
    endtask : t_id
    task automatic t_mode();
        wr(OFF_MODE01, 32'h00ABC123);
        wr(OFF_MODE2, 32'h000002A5);
        wr(OFF_IDCFG, 32'h0015A3C0);
        chk(r, RESP_OKAY);
        rd(OFF_MODE2);
        chk(d, 32'h000002A5);
        rd(12'h010);
        chk(r, RESP_SLVERR);
        ir(INS_DUAL_MR);
        ctl_u.scan(1'b0, 136'h0, 32, q);
        chk(q[31:0], {3'h0, 12'hABC, 3'h0, 1'b1, 12'h123, 1'b1});
        ir(INS_THIRD_MR);
        ctl_u.scan(1'b0, 136'h0, 32, q);
        chk(q[31:0], {21'h0, 10'h2A5, 1'b1});
    endtask : t_mode
    task automatic t_bsr();
        ir(INS_SAMPLE);
        ctl_u.scan(1'b0, 136'h1, 136, q);
        chk(q, {1'b1, ring_in});
        ir(INS_EXTEST);
        ctl_u.scan(1'b0, {1'b0, ~ring_in}, 135, q);
        chk(q[134:0], ring_in);
        chk({pin_out, pin_oe}, {~ring_in, {135{1'b1}}});
    endtask : t_bsr
    task automatic t_byp();
        logic [7:0] c[4];
        logic [134:0] e[4];
        c = '{INS_BYPASS, INS_CLAMP, INS_HIGHZ, 8'h42};
        e = '{core_oe, {135{1'b1}}, 135'h0, core_oe};
        for (int i = 0; i < 4; i++) begin
            ir(c[i]);
            ctl_u.scan(1'b0, 136'h1, 2, q);
            chk(q[1:0], 2'h2);
            chk(pin_oe, e[i]);
        end
    endtask : t_byp
    task automatic stop_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_id();
        t_mode();
        t_bsr();
        t_byp();
        t_id();
        stop_test();
    end
    initial begin
        #300us;
        error_cnt++;
        stop_test();
    end
endmodule : jtag_scan_register_set_tb

// *** sim/scan_assertions.sv ***
// Bus handshake and scan pin checks
`timescale 1ns/1ps
module scan_assertions import scan_pkg::*; (
    input wire logic sys_clk, rst_n, tck, tdo, s_axi_rvalid, s_axi_rready,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic [1:0] s_axi_bresp, s_axi_rresp,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
    aw_stall_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready high after take");
    w_stall_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("wready high after take");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp)
        && s_axi_bvalid) else $error("write answer dropped");
    b_clear_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    r_answer_a: assert property (ar_take |=> s_axi_rvalid) else $error("read late");
    r_hold_a: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    bad_read_a: assert property (ar_take ##0 s_axi_araddr > 12'h00C |=> s_axi_rdata == 32'h0
        && s_axi_rresp == RESP_SLVERR) else $error("unmapped read");
    tdo_edge_a: assert property ($changed(tdo) |-> !tck) else $error("tdo moved, tck high");
endmodule : scan_assertions
bind scan_register_set scan_assertions chk_u (.*);

// *** sim/tap_ctrl_model.sv ***
// Test controller model; tck idles low between frames
`timescale 1ns/1ps
module tap_ctrl_model (
    input  wire logic sys_clk, tdo,
    output logic      tck = 1'b0, tms = 1'b1, tdi = 1'b0
);
    // One tck period; tdo is sampled just before the rise
    task automatic step(input logic m, d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (16) @(posedge sys_clk);
        o = tdo;
        tck <= 1'b1;
        repeat (16) @(posedge sys_clk);
        tck <= 1'b0;
    endtask : step
    // Capture, shift n bits LSB first, update, back to idle
    task automatic scan(input logic ir, input logic [135:0] din, input int n,
                        output logic [135:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : scan
    // Walk to test-logic-reset, then idle
    task automatic tlr();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : tlr
endmodule : tap_ctrl_model
